// File: verif/led_pwm_output_sequencer_bench.sv
`timescale 1ns/1ps
module led_pwm_output_sequencer_bench;
    localparam int LAG = 2;
    logic sys_clk, rstn, ref_clk, load_cmd, apply_cmd, sync_sel, div_sel, stag_dis;
    logic ot_off, ot_flag, pwm_busy, apply_busy, prev0;
    logic [1:0] res_sel;
    logic [3:0] channel;
    logic [15:0] data, sink;
    int miscompares, comparisons, ref_tick, on_cnt, pulses;
    int rise_t [16];

    led_pwm_output_sequencer #(.STAGGER_LAG(LAG)) led_pwm_output_sequencer_inst (
        .SYS_CLK(sys_clk), .RSTN(rstn), .GRAYSCALE_REF_CLOCK(ref_clk),
        .GRAYSCALE_LOAD_CMD(load_cmd), .GRAYSCALE_APPLY_CMD(apply_cmd),
        .LOAD_CHANNEL(channel), .LOAD_DATA(data), .SYNC_SELECT_BIT(sync_sel),
        .DIVISION_SELECT_BIT(div_sel), .STAGGER_DISABLE_BIT(stag_dis),
        .RESOLUTION_SEL(res_sel), .OVERTEMP_SHUTDOWN_OFF(ot_off), .OVERTEMP_FLAG(ot_flag),
        .SINK_CHANNEL(sink), .PWM_BUSY(pwm_busy), .APPLY_BUSY(apply_busy));

    pwm_host_model pwm_host_model_inst (.clk(sys_clk), .load_cmd(load_cmd),
        .apply_cmd(apply_cmd), .channel(channel), .data(data));

    // System clock 8 ns, link clock 80 ns with an unrelated phase
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        ref_clk = 1'b0;
        #17;
        forever #40 ref_clk = ~ref_clk;
    end

    // Sink observation on the falling edge, clear of output updates
    always @(negedge ref_clk) begin
        ref_tick = ref_tick + 1;
        if (sink[0] === 1'b1) on_cnt = on_cnt + 1;
        if (sink[0] === 1'b1 && prev0 !== 1'b1) pulses = pulses + 1;
        prev0 = sink[0];
        for (int i = 0; i < 16; i++) if (sink[i] === 1'b1 && rise_t[i] < 0) rise_t[i] = ref_tick;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic clear_obs();
        on_cnt = 0;
        pulses = 0;
        foreach (rise_t[i]) rise_t[i] = -1;
    endtask

    task automatic ref_wait(input int n);
        repeat (n) @(posedge ref_clk);
        @(posedge sys_clk);
        #1;
    endtask

    // Bounded wait for the period indication to reach a level
    task automatic wait_busy(input logic val);
        int n;
        n = 0;
        while (pwm_busy !== val && n < 40000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check("busy wait", pwm_busy, val);
        if (pwm_busy !== val) end_of_test();
    endtask

    // Wait for a free apply path, then send a full bank
    task automatic start_bank(input logic [15:0] v0, input logic [15:0] rest);
        int n;
        n = 0;
        while (apply_busy !== 1'b0 && n < 1000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check("apply free", apply_busy, 0);
        if (apply_busy !== 1'b0) end_of_test();
        pwm_host_model_inst.send_bank(v0, rest);
    endtask

    task automatic run_bank(input logic [15:0] v0, input logic [15:0] rest);
        clear_obs();
        start_bank(v0, rest);
        wait_busy(1'b1);
        wait_busy(1'b0);
    endtask

    task automatic t_reset();
        check("sink after reset", sink, 0);
        check("busy after reset", {pwm_busy, apply_busy}, 0);
    endtask

    task automatic t_normal();
        run_bank(3, 3);
        check("on time", on_cnt, 3);
        for (int i = 1; i < 16; i++) check("together", rise_t[i], rise_t[0]);
        ref_wait(100);
        check("idle on time", on_cnt, 3);
        check("idle sink", sink, 0);
    endtask

    task automatic t_stagger();
        stag_dis = 1'b0;
        run_bank(4, 4);
        check("stagger on time", on_cnt, 4);
        for (int k = 0; k < 16; k++) begin
            check("lag", rise_t[pwm_seq_pkg::STAGGER_ORDER[k]] - rise_t[0], k * LAG);
        end
        stag_dis = 1'b1;
    endtask

    task automatic t_divided();
        div_sel = 1'b1;
        run_bank(256, 256);
        check("divided on time", on_cnt, 256);
        check("divided pulses", pulses, 128);
        div_sel = 1'b0;
    endtask

    // Applies during a period: sync defers and keeps the last, async restarts
    task automatic t_applies(input logic async_mode);
        sync_sel = async_mode;
        clear_obs();
        start_bank(20, 0);
        wait_busy(1'b1);
        ref_wait(100);
        if (!async_mode) start_bank(30, 0);
        start_bank(7, 0);
        ref_wait(async_mode ? 20 : 300);
        check("on time mid period", on_cnt, async_mode ? 27 : 20);
        wait_busy(1'b0);
        check("on time total", on_cnt, 27);
        sync_sel = 1'b0;
    endtask

    task automatic t_overtemp();
        clear_obs();
        start_bank(1000, 1000);
        wait_busy(1'b1);
        ref_wait(50);
        ot_flag = 1'b1;
        ref_wait(5);
        check("forced off", sink, 0);
        ot_flag = 1'b0;
        ref_wait(5);
        check("resumed", sink, 16'hffff);
        ot_off = 1'b1;
        ref_wait(2);
        ot_flag = 1'b1;
        ref_wait(5);
        check("shutdown disabled", sink, 16'hffff);
        ot_flag = 1'b0;
        ot_off = 1'b0;
        wait_busy(1'b0);
    endtask

    // Main sequence
    initial begin
        miscompares = 0;
        comparisons = 0;
        ref_tick = 0;
        prev0 = 1'b0;
        clear_obs();
        {sync_sel, div_sel, ot_off, ot_flag} = 4'h0;
        stag_dis = 1'b1;
        res_sel = 2'h3; // 10-bit periods keep the run short
        rstn = 1'b0;
        repeat (5) @(posedge ref_clk);
        @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        t_reset();
        t_normal();
        t_stagger();
        t_divided();
        t_applies(1'b0);
        ref_wait(1);
        t_applies(1'b1);
        t_overtemp();
        end_of_test();
    end
endmodule // led_pwm_output_sequencer_bench

// File: verif/pwm_host_model.sv
`timescale 1ns/1ps
module pwm_host_model (
    input wire logic clk,
    output logic load_cmd,
    output logic apply_cmd,
    output logic [pwm_seq_pkg::CH_W-1:0] channel,
    output logic [pwm_seq_pkg::GS_W-1:0] data
);
    // Idle strobes from time zero
    initial begin
        load_cmd = 1'b0;
        apply_cmd = 1'b0;
        channel = 4'h0;
        data = 16'h0000;
    end

    // One word per strobe; word lines scrambled once the strobe drops
    task automatic put(input logic apply, input logic [3:0] ch, input logic [15:0] d);
        @(posedge clk);
        #1;
        load_cmd = !apply;
        apply_cmd = apply;
        channel = ch;
        data = d;
        @(posedge clk);
        #1;
        load_cmd = 1'b0;
        apply_cmd = 1'b0;
        channel = ~ch;
        data = ~d;
    endtask

    // Fifteen loads, then an apply carrying the last word
    task automatic send_bank(input logic [15:0] ch0_val, input logic [15:0] rest_val);
        for (int i = 0; i < 15; i++) begin
            put(1'b0, 4'(i), (i == 0) ? ch0_val : rest_val);
        end
        put(1'b1, 4'hf, rest_val);
    endtask
endmodule // pwm_host_model

// File: verilog/bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // bit_sync

// File: verilog/led_pwm_output_sequencer.sv
`timescale 1ns/1ps
module led_pwm_output_sequencer #(
    parameter int STAGGER_LAG = pwm_seq_pkg::STAGGER_LAG_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic GRAYSCALE_REF_CLOCK,
    input wire logic GRAYSCALE_LOAD_CMD,
    input wire logic GRAYSCALE_APPLY_CMD,
    input wire logic [pwm_seq_pkg::CH_W-1:0] LOAD_CHANNEL,
    input wire logic [pwm_seq_pkg::GS_W-1:0] LOAD_DATA,
    input wire logic SYNC_SELECT_BIT,
    input wire logic DIVISION_SELECT_BIT,
    input wire logic STAGGER_DISABLE_BIT,
    input wire logic [1:0] RESOLUTION_SEL,
    input wire logic OVERTEMP_SHUTDOWN_OFF,
    input wire logic OVERTEMP_FLAG,
    output logic [pwm_seq_pkg::NUM_CH-1:0] SINK_CHANNEL,
    output logic PWM_BUSY,
    output logic APPLY_BUSY
);
    localparam int NCH = pwm_seq_pkg::NUM_CH;
    localparam int GW = pwm_seq_pkg::GS_W;
    localparam int CW = pwm_seq_pkg::CNT_W;
    localparam logic [CW-1:0] STAG_EXT = CW'((NCH - 1) * STAGGER_LAG);

    // System-clock side state
    logic [GW-1:0] load_bank [NCH];
    logic [GW-1:0] staging [NCH];
    logic [pwm_seq_pkg::SET_W-1:0] settings_r;
    logic req_tgl_r;
    logic defer_r;
    logic [1:0] back_s;
    // Reference-clock side state
    pwm_seq_pkg::seq_state_t state_r, state_nxt;
    logic [GW-1:0] next_gs [NCH];
    logic [GW-1:0] active_gs [NCH];
    logic next_valid_r;
    logic req_seen_r;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [pwm_seq_pkg::SHIFT_W-1:0] shift_r;
    logic div_r;
    logic stag_r;
    logic req_s;
    logic [pwm_seq_pkg::XSET_W-1:0] set_s;
    logic [NCH-1:0] on_vec;
    logic [NCH-1:0] sink_nxt;

    pwm_timing_if tim();

    // Handshake status seen from the system clock
    wire ack_s = back_s[0];
    wire hs_busy = req_tgl_r != ack_s;
    wire launch = !hs_busy && (GRAYSCALE_APPLY_CMD || defer_r);
    wire word_we = GRAYSCALE_LOAD_CMD || GRAYSCALE_APPLY_CMD;

    assign APPLY_BUSY = hs_busy || defer_r;
    assign PWM_BUSY = back_s[1];

    // Settings held from the control logic, defaults after reset
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            settings_r <= pwm_seq_pkg::SET_RST;
        end else begin
            settings_r <= {OVERTEMP_SHUTDOWN_OFF, STAGGER_DISABLE_BIT, DIVISION_SELECT_BIT,
                           SYNC_SELECT_BIT, RESOLUTION_SEL};
        end
    end

    // Apply toggles the request; an apply during a busy handshake is deferred
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            req_tgl_r <= 1'b0;
            defer_r <= 1'b0;
        end else begin
            req_tgl_r <= launch ? !req_tgl_r : req_tgl_r;
            defer_r <= (GRAYSCALE_APPLY_CMD && hs_busy) || (defer_r && !launch);
        end
    end

    // Per-channel load bank and staging words
    for (genvar c = 0; c < NCH; c++) begin : g_bank
        localparam logic [pwm_seq_pkg::CH_W-1:0] CH = pwm_seq_pkg::CH_W'(c);
        wire hit = word_we && (LOAD_CHANNEL == CH);
        wire [GW-1:0] bank_nxt = hit ? LOAD_DATA : load_bank[c];

        always_ff @(posedge SYS_CLK or negedge RSTN) begin
            if (!RSTN) begin
                load_bank[c] <= pwm_seq_pkg::GS_RST;
                staging[c] <= pwm_seq_pkg::GS_RST;
            end else begin
                load_bank[c] <= bank_nxt;
                staging[c] <= launch ? bank_nxt : staging[c];
            end
        end
    end

    // Status back to the system clock
    bit_sync #(.W(2)) u_back_sync (
        .clk(SYS_CLK),
        .rst_n(RSTN),
        .d({state_r == pwm_seq_pkg::SEQ_RUN, req_seen_r}),
        .q(back_s)
    );

    // Request toggle into the reference clock
    bit_sync #(.W(1)) u_req_sync (
        .clk(GRAYSCALE_REF_CLOCK),
        .rst_n(RSTN),
        .d(req_tgl_r),
        .q(req_s)
    );

    // Settings and overtemperature indication into the reference clock
    bit_sync #(.W(pwm_seq_pkg::XSET_W)) u_set_sync (
        .clk(GRAYSCALE_REF_CLOCK),
        .rst_n(RSTN),
        .d({OVERTEMP_FLAG, settings_r}),
        .q(set_s)
    );

    // Decoded settings in the reference domain
    wire [1:0] res_sel_s = set_s[pwm_seq_pkg::SET_RES_LSB +: 2];
    wire async_s = set_s[pwm_seq_pkg::SET_ASYNC];
    wire div_s = set_s[pwm_seq_pkg::SET_DIV];
    wire stag_en_s = !set_s[pwm_seq_pkg::SET_STAG_DIS];
    wire shutdown = set_s[pwm_seq_pkg::SET_OT_FLAG] && !set_s[pwm_seq_pkg::SET_OT_OFF];
    wire [pwm_seq_pkg::SHIFT_W-1:0] shift_nxt = pwm_seq_pkg::SHIFT_W'(pwm_seq_pkg::RES_MAX_BITS
        - pwm_seq_pkg::RES_STEP_BITS * int'(res_sel_s));

    // Period length and sequencing conditions
    wire running = state_r == pwm_seq_pkg::SEQ_RUN;
    wire [CW-1:0] plen_total = (CW'(1) << shift_r) + (stag_r ? STAG_EXT : CW'(0));
    wire period_end = running && (cnt_r == plen_total - CW'(1));
    wire new_req = req_s != req_seen_r;
    wire start = next_valid_r && (!running || async_s || period_end);
    wire [GW-1:0] sub_mask = GW'((CW'(1) << (shift_r - pwm_seq_pkg::SHIFT_W'(pwm_seq_pkg::SUB_W)))
        - CW'(1));

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            pwm_seq_pkg::SEQ_IDLE: begin
                cnt_nxt = '0;
                if (start) begin
                    state_nxt = pwm_seq_pkg::SEQ_RUN;
                end
            end
            pwm_seq_pkg::SEQ_RUN: begin
                cnt_nxt = start ? CW'(0) : cnt_r + CW'(1);
                if (period_end && !start) begin
                    state_nxt = pwm_seq_pkg::SEQ_IDLE;
                end
            end
            default: begin
                state_nxt = pwm_seq_pkg::SEQ_IDLE;
                cnt_nxt = '0;
            end
        endcase
    end

    // Sequencer registers; period settings frozen at each start
    always_ff @(posedge GRAYSCALE_REF_CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= pwm_seq_pkg::SEQ_IDLE;
            cnt_r <= '0;
            req_seen_r <= 1'b0;
            next_valid_r <= 1'b0;
            shift_r <= pwm_seq_pkg::SHIFT_W'(pwm_seq_pkg::RES_MAX_BITS);
            div_r <= 1'b0;
            stag_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            req_seen_r <= req_s;
            next_valid_r <= new_req || (next_valid_r && !start);
            shift_r <= start ? shift_nxt : shift_r;
            div_r <= start ? div_s : div_r;
            stag_r <= start ? stag_en_s : stag_r;
        end
    end

    assign tim.cnt = cnt_r;
    assign tim.shift = shift_r;
    assign tim.div = div_r;

    // Per-channel next and active data, with the comparator
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        localparam logic [CW-1:0] OFS = CW'(pwm_seq_pkg::stagger_pos(c) * STAGGER_LAG);
        wire [CW-1:0] ofs = stag_r ? OFS : CW'(0);

        always_ff @(posedge GRAYSCALE_REF_CLOCK or negedge RSTN) begin
            if (!RSTN) begin
                next_gs[c] <= pwm_seq_pkg::GS_RST;
                active_gs[c] <= pwm_seq_pkg::GS_RST;
            end else begin
                next_gs[c] <= new_req ? staging[c] : next_gs[c];
                active_gs[c] <= start ? next_gs[c] : active_gs[c];
            end
        end

        pwm_slot_compare u_slot (
            .tim(tim.slot),
            .gs(active_gs[c]),
            .offset(ofs),
            .on(on_vec[c])
        );
    end

    // Channel outputs, forced off during overtemperature
    assign sink_nxt = (running && !shutdown) ? on_vec : '0;

    always_ff @(posedge GRAYSCALE_REF_CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            SINK_CHANNEL <= pwm_seq_pkg::SINK_RST;
        end else begin
            SINK_CHANNEL <= sink_nxt;
        end
    end

    default clocking cb @(posedge GRAYSCALE_REF_CLOCK); endclocking
    default disable iff (!RSTN);

    // Checks on the reference-clock side
    // Async apply: restart from count zero
    AST_ASYNC_RESTART: assert property (
        running && next_valid_r && async_s
        |=> running && cnt_r == '0)
        else $error("async apply did not restart the period");
    // Sync apply: running count undisturbed
    AST_SYNC_WAIT: assert property (
        running && next_valid_r && !async_s && !period_end
        |=> running && cnt_r == CW'($past(cnt_r) + CW'(1)))
        else $error("sync apply disturbed the running period");
    // Sync apply: new period right after the last count
    AST_SYNC_HANDOVER: assert property (
        period_end && next_valid_r && !async_s
        |=> running && cnt_r == '0)
        else $error("sync apply did not start at the period end");
    // Period starts with the latest captured data
    AST_LAST_DATA: assert property (
        start
        |=> active_gs[0] == $past(next_gs[0])
        && active_gs[NCH-1] == $past(next_gs[NCH-1]))
        else $error("period did not start with the latest data");
    // No new apply: idle and dark after the period
    AST_ONE_PERIOD: assert property (
        period_end && !next_valid_r
        |=> state_r == pwm_seq_pkg::SEQ_IDLE ##1 SINK_CHANNEL == '0)
        else $error("output continued without a new apply");
    // Idle sequencer keeps every channel off
    AST_IDLE_DARK: assert property (
        !running |=> SINK_CHANNEL == '0)
        else $error("channel on while no period runs");
    // Overtemperature forces every channel off
    AST_OT_OFF: assert property (
        shutdown |=> SINK_CHANNEL == '0)
        else $error("channels on during overtemperature");
    // Outside overtemperature the comparators drive the channels
    AST_OT_RESUME: assert property (
        !shutdown && running |=> SINK_CHANNEL == $past(on_vec))
        else $error("channels not following data outside overtemperature");
    // Second channel in order waits one lag
    AST_STAGGER_LAG: assert property (
        running && stag_r && cnt_r < CW'(STAGGER_LAG)
        |-> !on_vec[NCH-1])
        else $error("second channel in order switched without lag");
    // Divided output: on at every sub-period start
    AST_DIV_SPREAD: assert property (
        running && div_r && !stag_r && (cnt_r[GW-1:0] & sub_mask) == '0
        && (active_gs[0] & GW'((CW'(1) << shift_r) - CW'(1))) >= 16'h0080
        |-> on_vec[0])
        else $error("divided output missed a sub-period");
    // Plain output follows count against data
    AST_PLAIN_COMPARE: assert property (
        running && !div_r && !stag_r && cnt_r < (CW'(1) << shift_r)
        |-> on_vec[0] == (cnt_r[GW-1:0] < (active_gs[0] & GW'((CW'(1) << shift_r) - CW'(1)))))
        else $error("plain output does not follow the count");
    // Count never runs past the period length
    AST_CNT_BOUND: assert property (
        running |-> cnt_r < plen_total)
        else $error("period count beyond its length");

    // Main scenarios reached
    COV_ASYNC_RESTART: cover property (running && next_valid_r && async_s && !period_end);
    COV_SYNC_QUEUED: cover property (running && new_req && !async_s ##[1:1000] period_end);
    COV_OT_DURING_RUN: cover property (running && shutdown);
    COV_DIV_RUN: cover property (period_end && div_r);
    COV_STAGGER_RUN: cover property (period_end && stag_r);
endmodule // led_pwm_output_sequencer

// File: verilog/pwm_seq_pkg.sv
package pwm_seq_pkg;
    // Channel and data geometry
    localparam int NUM_CH = 16;
    localparam int CH_W = 4;
    localparam int GS_W = 16;
    localparam int CNT_W = 20;
    localparam int SHIFT_W = 5;
    // Divided output: sub-periods per period
    localparam int SUB_PERIODS = 128;
    localparam int SUB_W = 7;
    // Resolution select: 16 bits minus two per step
    localparam int RES_MAX_BITS = 16;
    localparam int RES_STEP_BITS = 2;
    // Setting word field positions
    localparam int SET_RES_LSB = 0;
    localparam int SET_ASYNC = 2;
    localparam int SET_DIV = 3;
    localparam int SET_STAG_DIS = 4;
    localparam int SET_OT_OFF = 5;
    localparam int SET_OT_FLAG = 6;
    localparam int SET_W = 6;
    localparam int XSET_W = 7;
    // Values after reset
    localparam logic [SET_W-1:0] SET_RST = 6'h00;
    localparam logic [GS_W-1:0] GS_RST = 16'h0000;
    localparam logic [NUM_CH-1:0] SINK_RST = 16'h0000;
    // Channel lag: least time in ns, rounded up to reference clocks
    localparam int REF_CLK_PERIOD_NS = 80;
    localparam int STAGGER_LAG_NS = 4;
    localparam int STAGGER_LAG_CYC_RAW = (STAGGER_LAG_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
    localparam int STAGGER_LAG_CYC = (STAGGER_LAG_CYC_RAW < 1) ? 1 : STAGGER_LAG_CYC_RAW;
    // Switching order of the channels
    localparam logic [CH_W-1:0] STAGGER_ORDER [NUM_CH] = '{
        4'h0, 4'hf, 4'h7, 4'h8, 4'h1, 4'he, 4'h6, 4'h9,
        4'h2, 4'hd, 4'h5, 4'ha, 4'h3, 4'hc, 4'h4, 4'hb};

    typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_t;

    // Slot of a channel within the switching order
    function automatic int stagger_pos(input int ch);
        int pos;
        pos = 0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (int'(STAGGER_ORDER[i]) == ch) begin
                pos = i;
            end
        end
        return pos;
    endfunction
endpackage

// File: verilog/pwm_slot_compare.sv
`timescale 1ns/1ps
module pwm_slot_compare (
    pwm_timing_if.slot tim,
    input wire logic [pwm_seq_pkg::GS_W-1:0] gs,
    input wire logic [pwm_seq_pkg::CNT_W-1:0] offset,
    output logic on
);
    localparam int GW = pwm_seq_pkg::GS_W;
    localparam int CW = pwm_seq_pkg::CNT_W;
    localparam int SW = pwm_seq_pkg::SUB_W;

    // Local count, shifted by the channel lag, and window of one period
    wire [CW-1:0] local_cnt = tim.cnt - offset;
    wire [CW-1:0] plen = CW'(1) << tim.shift;
    wire in_win = (tim.cnt >= offset) && (local_cnt < plen);
    wire [GW-1:0] lc = local_cnt[GW-1:0];
    wire [GW-1:0] gmask = GW'(plen - CW'(1));
    wire [GW-1:0] gsm = gs & gmask;
    // Divided output: quotient spread over each sub-period, remainder by bit-reversed index
    wire [pwm_seq_pkg::SHIFT_W-1:0] sub_shift = tim.shift - pwm_seq_pkg::SHIFT_W'(SW);
    wire [SW-1:0] sub_idx = SW'(lc >> sub_shift);
    wire [SW-1:0] sub_rev = {<<{sub_idx}};
    wire [GW-1:0] pos = lc & ((GW'(1) << sub_shift) - GW'(1));
    wire [GW-1:0] quo = gsm >> SW;
    wire [SW-1:0] rem = gsm[SW-1:0];
    wire div_on = (pos < quo) || ((pos == quo) && (sub_rev < rem));
    wire plain_on = lc < gsm;

    assign on = in_win && (tim.div ? div_on : plain_on);
endmodule // pwm_slot_compare

// File: verilog/pwm_timing_if.sv
`timescale 1ns/1ps
// Period timing shared by all channel comparators
interface pwm_timing_if;
    logic [pwm_seq_pkg::CNT_W-1:0] cnt;
    logic [pwm_seq_pkg::SHIFT_W-1:0] shift;
    logic div;
    modport src (output cnt, output shift, output div);
    modport slot (input cnt, input shift, input div);
endinterface
